// File: rtl/cpu_sru_pkg.sv
// Constants, register map and carrier types for the CPU special register unit
// What this block does
// - Extended table read and flash write use pointer extension above the 16-bit pointer.
// - Plain flash table read ignores the extension and uses the 16-bit pointer.
// - Extended indirect jump and call take the jump extension as top byte.
// - Short indirect jump and plain call never use the jump extension.
// - Extension registers keep only implemented bits; the rest read zero.
// - Pointer extensions widen all three data pointers to a 24-bit data space.
// - Low byte write goes to temporary; high byte write commits both together.
// - Low byte read latches upper bytes; later reads return the latched copy.
// - Temporary registers are directly readable and writable.
// - Two temporaries serve 24-bit registers, three serve 32-bit ones.
// - Key 0xd8 opens register mode, key 0x9d opens instruction mode.
// - An open mode lasts at most four instructions, then protected actions refused.
// - Register mode closes on any I/O write except a non-key guard write, and on a data write, flash op or sleep.
// - Instruction mode closes on a data memory write or sleep.
// - No interrupt is taken while a window is open; requests stay pending.
// - Guard reads show register mode in bit 0, instruction mode in bit 1.
// - Stack low byte write holds interrupts four instructions or until an I/O write.
// - Stack pointer is 16 bits from both bytes, reset to the SRAM top.
// - Stack pointer keeps only bits for present data memory; others read zero.
// - Programmed lock fuse rejects every change to the guarded control register.
package cpu_sru_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_GUARD = 8'h04;
    localparam logic [7:0] IDX_FPEXT = 8'h0b;
    localparam logic [7:0] IDX_JEXT = 8'h0c;
    localparam logic [7:0] IDX_SPL = 8'h0d;
    localparam logic [7:0] IDX_SPH = 8'h0e;
    localparam logic [7:0] IDX_TEMP0 = 8'h20;
    localparam logic [7:0] IDX_XEXT = 8'h24;
    localparam logic [7:0] IDX_YEXT = 8'h25;
    localparam logic [7:0] IDX_WIDE0 = 8'h28;
    localparam logic [7:0] IDX_MID0 = 8'h2c;
    localparam logic [7:0] IDX_GCTRL = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;

    // Guard keys and field positions
    localparam logic [7:0] KEY_REG_MODE = 8'hd8;
    localparam logic [7:0] KEY_INSTR_MODE = 8'h9d;
    localparam int GUARD_REG_BIT = 0;
    localparam int GUARD_INSTR_BIT = 1;
    localparam int GCTRL_CHANGE_EN_BIT = 7;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_SPLHOLD_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;

    // Instruction counts for the guard window and the stack hold
    localparam logic [2:0] GUARD_WINDOW_INSTR = 3'h4;
    localparam logic [2:0] SPL_HOLD_INSTR = 3'h4;

    // Reset values
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [31:0] SCRATCH_RESET = 32'h00000000;
    localparam logic [6:0] GCTRL_RESET = 7'h00;

    // Data pointer select codes
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;

    // Per-cycle events from the CPU core, same clock
    typedef struct packed {
        logic instrRetire;
        logic ioWrite;
        logic dataWrite;
        logic flashWrite;
        logic flashRead;
        logic extFlashRead;
        logic sleepExec;
        logic shortJump;
        logic extJump;
        logic [1:0] ptrSel;
        logic [15:0] xPtr;
        logic [15:0] yPtr;
        logic [15:0] zPtr;
    } core_evt_t;

    // Addresses formed for the core
    typedef struct packed {
        logic [23:0] flashAddr;
        logic [23:0] jumpAddr;
        logic [23:0] dataAddr;
    } core_addr_t;

endpackage

// File: rtl/cpu_special_register_unit.sv
// CPU special registers: change guard, pointer extensions, stack pointer, multi-byte temporaries
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
module cpu_special_register_unit import cpu_sru_pkg::*; #(
    parameter int FPEXT_BITS = 8,
    parameter int JEXT_BITS = 8,
    parameter int DEXT_BITS = 8,
    parameter int SP_BITS = 16,
    parameter logic [15:0] SRAM_TOP = 16'h3fff
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire core_evt_t coreEvt,
    input wire logic lockFusePin,
    output core_addr_t coreAddr,
    output logic irqHold,
    output logic flashGrant,
    output logic [15:0] stackTop,
    output logic [6:0] guardedCtrl
);

    // Mask of the low n bits of a byte
    function automatic logic [7:0] lowMask8(input int n);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Mask of the low n bits of a half word
    function automatic logic [15:0] lowMask16(input int n);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (i < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    localparam logic [7:0] FP_MASK = lowMask8(FPEXT_BITS);
    localparam logic [7:0] JE_MASK = lowMask8(JEXT_BITS);
    localparam logic [7:0] DE_MASK = lowMask8(DEXT_BITS);
    localparam logic [15:0] SP_MASK = lowMask16(SP_BITS);

    typedef enum logic {
        BUS_ANSWER, // Zero: waitrequest low
        BUS_IDLE
    } bus_state_t;

    // State
    bus_state_t busState_ff, nxt_busState;
    logic [31:0] readData_ff, nxt_readData;
    logic regMode_ff, nxt_regMode;
    logic instrMode_ff, nxt_instrMode;
    logic [2:0] winCnt_ff, nxt_winCnt;
    logic splHold_ff, nxt_splHold;
    logic [2:0] splCnt_ff, nxt_splCnt;
    logic [7:0] fpExt_ff, nxt_fpExt;
    logic [7:0] jExt_ff, nxt_jExt;
    logic [7:0] xExt_ff, nxt_xExt;
    logic [7:0] yExt_ff, nxt_yExt;
    logic [15:0] sp_ff, nxt_sp;
    logic [7:0] temp_ff [0:2];
    logic [7:0] nxt_temp [0:2];
    logic [31:0] wide_ff, nxt_wide;
    logic [23:0] mid_ff, nxt_mid;
    logic [6:0] gCtrl_ff, nxt_gCtrl;
    logic refused_ff, nxt_refused;
    logic lockMeta_ff, lockSync_ff;
    core_addr_t addr_ff, nxt_addr;
    logic irqHold_ff, nxt_irqHold;
    logic flashGrant_ff, nxt_flashGrant;

    logic [7:0] idx;
    logic busRd, busWr, ioWriteAny;
    logic [7:0] wrByte;

    assign idx = avs_address[9:2];
    assign wrByte = avs_writedata[7:0];
    assign busRd = avs_read && (busState_ff == BUS_ANSWER);
    assign busWr = avs_write && (busState_ff == BUS_ANSWER) && avs_byteenable[0];
    // A bus write is itself an I/O memory write
    assign ioWriteAny = coreEvt.ioWrite || busWr;

    // Lock fuse arrives from a pin, two flops before use
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lockMeta_ff <= 1'b0;
            lockSync_ff <= 1'b0;
        end else begin
            lockMeta_ff <= lockFusePin;
            lockSync_ff <= lockMeta_ff;
        end
    end

    // Read multiplexer, sampled one cycle before the answer
    function automatic logic [7:0] readByte(input logic [7:0] i);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            IDX_GUARD: v = {6'h00, instrMode_ff, regMode_ff};
            IDX_FPEXT: v = fpExt_ff & FP_MASK;
            IDX_JEXT: v = jExt_ff & JE_MASK;
            IDX_XEXT: v = xExt_ff & DE_MASK;
            IDX_YEXT: v = yExt_ff & DE_MASK;
            IDX_SPL: v = sp_ff[7:0] & SP_MASK[7:0];
            IDX_SPH: v = temp_ff[0];
            IDX_GCTRL: v = {1'b0, gCtrl_ff};
            IDX_STATUS: v = {5'h00, refused_ff, splHold_ff, lockSync_ff};
            default: v = 8'h00;
        endcase
        for (int k = 0; k < 3; k++) begin
            if (i == IDX_TEMP0 + 8'(k)) begin
                v = temp_ff[k];
            end
        end
        // upper bytes come from the latched copy
        for (int k = 0; k < 4; k++) begin
            if (i == IDX_WIDE0 + 8'(k)) begin
                v = (k == 0) ? wide_ff[7:0] : temp_ff[k - 1];
            end
        end
        for (int k = 0; k < 3; k++) begin
            if (i == IDX_MID0 + 8'(k)) begin
                v = (k == 0) ? mid_ff[7:0] : temp_ff[k - 1];
            end
        end
        return v;
    endfunction

    // Avalon slave: one wait cycle, then the answer cycle
    always_comb begin
        nxt_busState = busState_ff;
        nxt_readData = readData_ff;
        case (busState_ff)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    nxt_busState = BUS_ANSWER;
                    nxt_readData = avs_read ? {24'h000000, readByte(idx)} : 32'h00000000;
                end
            end
            BUS_ANSWER: nxt_busState = BUS_IDLE;
            default: nxt_busState = BUS_IDLE;
        endcase
    end

    // Register file, temporaries and guard window
    always_comb begin
        logic closeReg, closeInstr, winExpire, splExpire;
        closeReg = 1'b0;
        closeInstr = 1'b0;
        winExpire = 1'b0;
        splExpire = 1'b0;
        nxt_regMode = regMode_ff;
        nxt_instrMode = instrMode_ff;
        nxt_winCnt = winCnt_ff;
        nxt_splHold = splHold_ff;
        nxt_splCnt = splCnt_ff;
        nxt_fpExt = fpExt_ff;
        nxt_jExt = jExt_ff;
        nxt_xExt = xExt_ff;
        nxt_yExt = yExt_ff;
        nxt_sp = sp_ff;
        nxt_temp = temp_ff;
        nxt_wide = wide_ff;
        nxt_mid = mid_ff;
        nxt_gCtrl = gCtrl_ff;
        nxt_refused = refused_ff;

        if ((regMode_ff || instrMode_ff) && coreEvt.instrRetire) begin
            nxt_winCnt = winCnt_ff + 3'h1;
            winExpire = (winCnt_ff + 3'h1) >= GUARD_WINDOW_INSTR;
        end
        closeReg = ioWriteAny || coreEvt.dataWrite || coreEvt.flashWrite
                   || coreEvt.flashRead || coreEvt.extFlashRead || coreEvt.sleepExec;
        closeInstr = coreEvt.dataWrite || coreEvt.sleepExec;
        if (closeReg || winExpire) begin
            nxt_regMode = 1'b0;
        end
        if (closeInstr || winExpire) begin
            nxt_instrMode = 1'b0;
        end

        // stack hold ends after four instructions or an I/O write
        if (splHold_ff && coreEvt.instrRetire) begin
            nxt_splCnt = splCnt_ff + 3'h1;
            splExpire = (splCnt_ff + 3'h1) >= SPL_HOLD_INSTR;
        end
        if (splExpire || ioWriteAny) begin
            nxt_splHold = 1'b0;
        end

        // low byte read latches the upper bytes
        if (busRd && idx == IDX_SPL) begin
            nxt_temp[0] = sp_ff[15:8] & SP_MASK[15:8];
        end
        // three temporaries for the 32-bit register
        if (busRd && idx == IDX_WIDE0) begin
            for (int k = 0; k < 3; k++) begin
                nxt_temp[k] = wide_ff[8 * (k + 1) +: 8];
            end
        end
        // two temporaries for the 24-bit register
        if (busRd && idx == IDX_MID0) begin
            for (int k = 0; k < 2; k++) begin
                nxt_temp[k] = mid_ff[8 * (k + 1) +: 8];
            end
        end

        if (busWr) begin
            case (idx)
                IDX_GUARD: begin
                    // key opens a mode, set wins over close
                    if (wrByte == KEY_REG_MODE) begin
                        nxt_regMode = 1'b1;
                        nxt_winCnt = 3'h0;
                    end else if (wrByte == KEY_INSTR_MODE) begin
                        nxt_instrMode = 1'b1;
                        nxt_winCnt = 3'h0;
                    end
                    if (wrByte != KEY_REG_MODE && wrByte != KEY_INSTR_MODE) begin
                        nxt_regMode = regMode_ff && !winExpire;
                        nxt_instrMode = instrMode_ff && !closeInstr && !winExpire;
                    end
                end
                IDX_FPEXT: nxt_fpExt = wrByte & FP_MASK;
                IDX_JEXT: nxt_jExt = wrByte & JE_MASK;
                IDX_XEXT: nxt_xExt = wrByte & DE_MASK;
                IDX_YEXT: nxt_yExt = wrByte & DE_MASK;
                IDX_SPL: begin
                    nxt_temp[0] = wrByte;
                    // hold starts, set wins over I/O write
                    nxt_splHold = 1'b1;
                    nxt_splCnt = 3'h0;
                end
                // high byte commits both halves at once
                IDX_SPH: nxt_sp = {wrByte, temp_ff[0]} & SP_MASK;
                IDX_GCTRL: begin
                    if (regMode_ff && !lockSync_ff && wrByte[GCTRL_CHANGE_EN_BIT]) begin
                        nxt_gCtrl = wrByte[6:0];
                    end else begin
                        nxt_refused = 1'b1;
                    end
                end
                IDX_STATUS: begin
                    if (wrByte[STAT_REFUSED_BIT]) begin
                        nxt_refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            for (int k = 0; k < 3; k++) begin
                if (idx == IDX_TEMP0 + 8'(k)) begin
                    nxt_temp[k] = wrByte;
                end
            end
            for (int k = 0; k < 4; k++) begin
                if (idx == IDX_WIDE0 + 8'(k)) begin
                    if (k < 3) begin
                        nxt_temp[k] = wrByte;
                    end else begin
                        nxt_wide = {wrByte, temp_ff[2], temp_ff[1], temp_ff[0]};
                    end
                end
            end
            for (int k = 0; k < 3; k++) begin
                if (idx == IDX_MID0 + 8'(k)) begin
                    if (k < 2) begin
                        nxt_temp[k] = wrByte;
                    end else begin
                        nxt_mid = {wrByte, temp_ff[1], temp_ff[0]};
                    end
                end
            end
        end
    end

    // Address forming and core-facing strobes
    always_comb begin
        nxt_addr.flashAddr = {8'h00, coreEvt.zPtr};
        // extension above Z for extended read and self-write
        if (coreEvt.extFlashRead || coreEvt.flashWrite) begin
            nxt_addr.flashAddr = {fpExt_ff & FP_MASK, coreEvt.zPtr};
        end
        // plain table read keeps the high byte zero
        if (coreEvt.flashRead) begin
            nxt_addr.flashAddr = {8'h00, coreEvt.zPtr};
        end
        // extended jump uses the jump extension
        // short jump and plain call stay in 16 bits
        nxt_addr.jumpAddr = coreEvt.extJump ? {jExt_ff & JE_MASK, coreEvt.zPtr} : {8'h00, coreEvt.zPtr};
        // X and Y get their own extension, Z takes the flash pointer extension
        case (coreEvt.ptrSel)
            PTR_X: nxt_addr.dataAddr = {xExt_ff & DE_MASK, coreEvt.xPtr};
            PTR_Y: nxt_addr.dataAddr = {yExt_ff & DE_MASK, coreEvt.yPtr};
            default: nxt_addr.dataAddr = {fpExt_ff & FP_MASK, coreEvt.zPtr};
        endcase
        // interrupts held while a window or stack hold is open
        nxt_irqHold = nxt_regMode || nxt_instrMode || nxt_splHold;
        // flash ops outside the instruction window get no grant
        nxt_flashGrant = instrMode_ff
                         && (coreEvt.flashWrite || coreEvt.flashRead || coreEvt.extFlashRead);
    end

    // Registers; stack pointer reset to SRAM top
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busState_ff <= BUS_IDLE;
            readData_ff <= 32'h00000000;
            regMode_ff <= 1'b0;
            instrMode_ff <= 1'b0;
            winCnt_ff <= 3'h0;
            splHold_ff <= 1'b0;
            splCnt_ff <= 3'h0;
            fpExt_ff <= EXT_RESET;
            jExt_ff <= EXT_RESET;
            xExt_ff <= EXT_RESET;
            yExt_ff <= EXT_RESET;
            sp_ff <= SRAM_TOP & SP_MASK;
            for (int k = 0; k < 3; k++) begin
                temp_ff[k] <= 8'h00;
            end
            wide_ff <= SCRATCH_RESET;
            mid_ff <= SCRATCH_RESET[23:0];
            gCtrl_ff <= GCTRL_RESET;
            refused_ff <= 1'b0;
            addr_ff <= '0;
            irqHold_ff <= 1'b0;
            flashGrant_ff <= 1'b0;
        end else begin
            busState_ff <= nxt_busState;
            readData_ff <= nxt_readData;
            regMode_ff <= nxt_regMode;
            instrMode_ff <= nxt_instrMode;
            winCnt_ff <= nxt_winCnt;
            splHold_ff <= nxt_splHold;
            splCnt_ff <= nxt_splCnt;
            fpExt_ff <= nxt_fpExt;
            jExt_ff <= nxt_jExt;
            xExt_ff <= nxt_xExt;
            yExt_ff <= nxt_yExt;
            sp_ff <= nxt_sp;
            temp_ff <= nxt_temp;
            wide_ff <= nxt_wide;
            mid_ff <= nxt_mid;
            gCtrl_ff <= nxt_gCtrl;
            refused_ff <= nxt_refused;
            addr_ff <= nxt_addr;
            irqHold_ff <= nxt_irqHold;
            flashGrant_ff <= nxt_flashGrant;
        end
    end

    // Outputs straight from flops
    assign avs_readdata = readData_ff;
    assign avs_waitrequest = busState_ff;
    assign coreAddr = addr_ff;
    assign irqHold = irqHold_ff;
    assign flashGrant = flashGrant_ff;
    assign stackTop = sp_ff;
    assign guardedCtrl = gCtrl_ff;

endmodule

// File: testbench/cpu_sru_chk.sv
// Concurrent checks on the special register unit ports
`timescale 1ns/1ns
module cpu_sru_chk import cpu_sru_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire core_evt_t coreEvt,
    input wire logic lockFusePin,
    input wire core_addr_t coreAddr,
    input wire logic irqHold,
    input wire logic flashGrant,
    input wire logic [15:0] stackTop,
    input wire logic [6:0] guardedCtrl
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [2:0] nxt_cnt;
    logic [2:0] cnt_ff;
    // Write answer edges by target
    wire wrAns = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire [7:0] wd = avs_writedata[7:0];
    wire keyWr = wrAns && avs_address[9:2] == IDX_GUARD && (wd == KEY_REG_MODE || wd == KEY_INSTR_MODE);
    wire splWr = wrAns && avs_address[9:2] == IDX_SPL;
    // Retires since the latest opening; a reopen restarts the count
    always_comb begin
        nxt_cnt = cnt_ff;
        if (keyWr || splWr || !irqHold) nxt_cnt = 3'h0;
        else if (coreEvt.instrRetire && cnt_ff != 3'h7) nxt_cnt = cnt_ff + 3'h1;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) cnt_ff <= 3'h0;
        else cnt_ff <= nxt_cnt;
    end
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    guard_bits_a: assert property (avs_read && !avs_waitrequest && avs_address[9:2] == IDX_GUARD |-> avs_readdata[31:2] == 30'h0)
        else $error("guard upper bits set");
    key_open_a: assert property (wrAns && avs_address[9:2] == IDX_GUARD && wd == KEY_REG_MODE |=> irqHold)
        else $error("key did not hold interrupts");
    spl_hold_a: assert property (splWr |=> irqHold && $stable(stackTop))
        else $error("low byte write misbehaved");
    window_max_a: assert property (irqHold |-> cnt_ff < 3'h4)
        else $error("hold longer than four instructions");
    fuse_lock_a: assert property (lockFusePin [*3] |=> $stable(guardedCtrl))
        else $error("locked control changed");
    plain_read_a: assert property (coreEvt.flashRead |=> coreAddr.flashAddr == {8'h00, $past(coreEvt.zPtr)})
        else $error("plain read used extension");
    grant_src_a: assert property (flashGrant |-> $past(coreEvt.flashWrite || coreEvt.flashRead || coreEvt.extFlashRead))
        else $error("grant without flash op");
    cover property (keyWr);
    cover property (flashGrant);
    cover property (splWr ##1 irqHold);
endmodule
bind cpu_special_register_unit cpu_sru_chk chk (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .coreEvt(coreEvt), .lockFusePin(lockFusePin),
    .coreAddr(coreAddr), .irqHold(irqHold), .flashGrant(flashGrant), .stackTop(stackTop), .guardedCtrl(guardedCtrl));

// File: testbench/cpu_core_model.sv
// Behavioural CPU core: one retire pulse per requested instruction
`timescale 1ns/1ns
module cpu_core_model import cpu_sru_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic fire,
    input wire logic [3:0] kind,
    input wire logic [1:0] sel,
    output core_evt_t coreEvt
);
    core_evt_t nxt_evt;
    core_evt_t evt_ff;
    // Pointers flip between instructions so stale values never match
    always_comb begin
        nxt_evt = '0;
        nxt_evt.ptrSel = sel;
        nxt_evt.xPtr = fire ? 16'h1111 : 16'heeee;
        nxt_evt.yPtr = fire ? 16'h2222 : 16'hdddd;
        nxt_evt.zPtr = fire ? 16'h3333 : 16'hcccc;
        nxt_evt.instrRetire = fire;
        // Kind 1..8 picks one event in struct order
        if (fire && kind != 4'h0) nxt_evt[57:50] = 8'h80 >> (kind - 4'h1);
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) evt_ff <= '0;
        else evt_ff <= nxt_evt;
    end
    assign coreEvt = evt_ff;
endmodule

// File: testbench/cpu_special_register_unit_test.sv
// Self-checking bench for the CPU special register unit
`timescale 1ns/1ns
module cpu_special_register_unit_test import cpu_sru_pkg::*;;
    typedef struct packed {logic [3:0] kind; logic [1:0] sel; logic [1:0] which; logic [23:0] exp;} row_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address = 10'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic lockFusePin = 1'b0;
    logic fire = 1'b0;
    logic [3:0] kind = 4'h0;
    logic [1:0] sel = 2'h0;
    logic irqHold, flashGrant;
    logic [15:0] stackTop;
    logic [6:0] guardedCtrl;
    logic [23:0] got;
    core_evt_t coreEvt;
    core_addr_t coreAddr;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    // Flash ext reads back masked to 5 bits (0x12) below
    row_t rows [8] = '{'{4'h5, 2'h0, 2'h0, 24'h123333}, '{4'h4, 2'h0, 2'h0, 24'h003333},
        '{4'h3, 2'h0, 2'h0, 24'h123333}, '{4'h8, 2'h0, 2'h1, 24'h343333}, '{4'h7, 2'h0, 2'h1, 24'h003333},
        '{4'h0, PTR_X, 2'h2, 24'h561111}, '{4'h0, PTR_Y, 2'h2, 24'h782222}, '{4'h0, 2'h2, 2'h2, 24'h123333}};
    logic [3:0] kinds [4] = '{4'h1, 4'h2, 4'h3, 4'h6};
    logic [7:0] keep [4] = '{8'h02, 8'h00, 8'h02, 8'h00};
    always #2 clk_sys = ~clk_sys;
    cpu_special_register_unit #(.FPEXT_BITS(5), .SP_BITS(14)) dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .coreEvt(coreEvt), .lockFusePin(lockFusePin), .coreAddr(coreAddr), .irqHold(irqHold),
        .flashGrant(flashGrant), .stackTop(stackTop), .guardedCtrl(guardedCtrl));
    cpu_core_model core_m (.clk_sys(clk_sys), .rst(rst), .fire(fire), .kind(kind), .sel(sel), .coreEvt(coreEvt));
    task complete_run;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until waitrequest is sampled low, released at that edge
    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address <= {idx, 2'h0};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        #1;
    endtask
    task w(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task r(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, {24'h0, e});
    endtask
    // One instruction from the core, then let its effect register
    task core(input logic [3:0] k, input logic [1:0] s = 2'h0);
        @(posedge clk_sys);
        fire <= 1'b1;
        kind <= k;
        sel <= s;
        @(posedge clk_sys);
        fire <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    // Hang guard; the whole run needs well under 3000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            complete_run;
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        r(IDX_GUARD, 8'h00);
        r(IDX_SPL, 8'hff);
        r(IDX_SPH, 8'h3f);
        r(8'h3f, 8'h00);
        chk(32'(stackTop), 32'h3fff);
        chk(32'(irqHold), 32'h0);
        w(IDX_FPEXT, 8'hf2);
        r(IDX_FPEXT, 8'h12);
        w(IDX_JEXT, 8'h34);
        w(IDX_XEXT, 8'h56);
        w(IDX_YEXT, 8'h78);
        $display("test reset and extensions done");
        for (int i = 0; i < 8; i++) begin
            core(rows[i].kind, rows[i].sel);
            got = rows[i].which == 2'h0 ? coreAddr.flashAddr : rows[i].which == 2'h1 ? coreAddr.jumpAddr : coreAddr.dataAddr;
            chk({8'h0, got}, {8'h0, rows[i].exp});
        end
        $display("test address rows done");
        // Software side writes and reads low byte first
        w(IDX_SPL, 8'h34);
        chk(32'(stackTop), 32'h3fff);
        chk(32'(irqHold), 32'h1);
        w(IDX_SPH, 8'hff);
        chk(32'(stackTop), 32'h3f34);
        chk(32'(irqHold), 32'h0);
        r(IDX_SPL, 8'h34);
        r(IDX_TEMP0, 8'h3f);
        w(IDX_TEMP0, 8'h2a);
        r(IDX_SPH, 8'h2a);
        w(IDX_SPL, 8'h34);
        repeat (3) core(4'h0);
        chk(32'(irqHold), 32'h1);
        core(4'h0);
        chk(32'(irqHold), 32'h0);
        for (int i = 0; i < 7; i++) w(8'(i < 4 ? IDX_WIDE0 + i : IDX_MID0 + i - 4), 8'(8'h11 * (i + 1)));
        for (int i = 0; i < 7; i++) r(8'(i < 4 ? IDX_WIDE0 + i : IDX_MID0 + i - 4), 8'(8'h11 * (i + 1)));
        $display("test multi-byte done");
        w(IDX_GUARD, KEY_REG_MODE);
        r(IDX_GUARD, 8'h01);
        chk(32'(irqHold), 32'h1);
        w(IDX_GCTRL, 8'h95);
        chk(32'(guardedCtrl), 32'h15);
        r(IDX_GUARD, 8'h00);
        w(IDX_GCTRL, 8'haa);
        chk(32'(guardedCtrl), 32'h15);
        r(IDX_STATUS, 8'h04);
        w(IDX_STATUS, 8'h04);
        // Three retires still inside the window, four already outside
        for (int n = 3; n < 5; n++) begin
            w(IDX_GUARD, KEY_REG_MODE);
            repeat (n) core(4'h0);
            w(IDX_GCTRL, 8'(8'h80 + n));
            chk(32'(guardedCtrl), 32'h03);
        end
        w(IDX_GUARD, KEY_REG_MODE);
        w(IDX_GCTRL, 8'h11);
        chk(32'(guardedCtrl), 32'h03);
        r(IDX_GUARD, 8'h00);
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 4; i++) begin
                w(IDX_GUARD, m == 1 ? KEY_INSTR_MODE : KEY_REG_MODE);
                core(kinds[i]);
                chk(32'(flashGrant), 32'(m * i == 2));
                r(IDX_GUARD, m == 1 ? keep[i] : 8'h00);
                repeat (4) core(4'h0);
            end
        end
        $display("test window closing done");
        w(IDX_GUARD, 8'h55);
        r(IDX_GUARD, 8'h00);
        w(IDX_GUARD, KEY_REG_MODE);
        w(IDX_GUARD, 8'h55);
        r(IDX_GUARD, 8'h01);
        core(4'h1);
        @(posedge clk_sys);
        lockFusePin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        w(IDX_GUARD, KEY_REG_MODE);
        w(IDX_GCTRL, 8'h8f);
        chk(32'(guardedCtrl), 32'h03);
        r(IDX_STATUS, 8'h05);
        $display("test other keys and fuse done");
        complete_run;
    end
endmodule
